// >>> design/ist_pkg.sv
// Shared constants, types and register map for the SCL timing block
package ist_pkg;

	// ------------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------------
	localparam logic [31:0] STD_LOW_ADDR   = 32'h5000_1318;
	localparam logic [31:0] FAST_HIGH_ADDR = 32'h5000_131c;
	localparam logic [31:0] FAST_LOW_ADDR  = 32'h5000_1320;
	localparam logic [31:0] INTR_STAT_ADDR = 32'h5000_132c;
	localparam logic [31:0] GC_CLR_ADDR    = 32'h5000_1368;

	// ------------------------------------------------------------------
	// Reset values, minimums and field positions
	// ------------------------------------------------------------------
	localparam logic [15:0] STD_LOW_RST   = 16'h004f;
	localparam logic [15:0] FAST_HIGH_RST = 16'h0008;
	localparam logic [15:0] FAST_LOW_RST  = 16'h0017;
	localparam logic [15:0] LOW_MIN       = 16'h0008;
	localparam logic [15:0] HIGH_MIN      = 16'h0006;
	localparam logic [15:0] IDLE_MARGIN   = 16'h000a;
	localparam logic [15:0] CNT_ONE       = 16'h0001;
	localparam logic [15:0] CNT_MAX       = 16'hffff;
	localparam int          GC_BIT        = 11;
	localparam int          GC_CLR_BIT    = 0;
	localparam logic [7:0]  GC_ADDR_BYTE  = 8'h00;
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	localparam logic [3:0]  BIT_ONE       = 4'h1;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SPD_STD  = 2'b01,
		SPD_FAST = 2'b10,
		SPD_HIGH = 2'b11
	} ist_speed_t;

	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_ADDR = 2'b01,
		LK_ACK  = 2'b10,
		LK_DATA = 2'b11
	} ist_link_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [31:0] addr;
		logic [15:0] wdata;
		logic [1:0]  be;
	} ist_reg_req_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} ist_bus_pins_t;

endpackage : ist_pkg

// >>> design/ist_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ist_sync #(
	parameter int              W   = 1,
	parameter logic [W-1:0]    RST = '0
) (
	input  wire logic          i_clk,
	input  wire logic          i_nrst,
	input  wire logic [W-1:0]  i_d,
	output logic      [W-1:0]  o_q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// First stage feeds only the second
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			s1_reg <= RST;
			s2_reg <= RST;
			s3_reg <= RST;
		end else begin
			s1_reg <= i_d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Output moves only once two stages agree
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_q <= RST;
		end else if (s2_reg == s3_reg) begin
			o_q <= s3_reg;
		end
	end

endmodule : ist_sync

// >>> design/ist_core.sv
// SCL period counts, bus idle detect and General Call flag
`timescale 1ns/1ps
// Notes on behaviour
// - Standard-speed SCL low phase is timed by a 16-bit software count.
// - Period count writes take effect only while the controller is off.
// - A low-phase count written below 8 is stored as 8.
// - Fast-speed SCL high phase uses a 16-bit count, minimum stored 6.
// - Fast-speed SCL low phase uses its own 16-bit count.
// - High-speed mode clocks its preamble with the fast counts.
// - The General Call flag sets only when that address is acknowledged.
// - The flag holds until disable or a read of the clear register.
// - Bytes after an acknowledged General Call go to the receive side.
// - Bus idle is flagged when a counter reaches standard high plus 10.
module ist_core (
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_nrst,
	input  wire logic                 i_link_clk,
	input  wire ist_pkg::ist_reg_req_t i_req,
	output logic [15:0]               o_reg_rdata,
	input  wire logic                 i_ctrl_enable,
	input  wire logic                 i_master_active,
	input  wire logic [1:0]           i_speed_mode,
	input  wire logic                 i_hs_preamble,
	input  wire logic [15:0]          i_std_high_count,
	input  wire logic                 i_scl_in,
	input  wire logic                 i_sda_in,
	output logic                      o_scl_out,
	output logic                      o_scl_oe,
	output logic                      o_sda_out,
	output logic                      o_sda_oe,
	output logic                      o_bus_idle,
	output logic                      o_gc_flag,
	output logic [7:0]                o_rx_data,
	output logic                      o_rx_valid
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [15:0] clamp_min(input logic [15:0] v,
	                                          input logic [15:0] m);
		clamp_min = (v < m) ? m : v;
	endfunction : clamp_min

	function automatic logic [15:0] merge_be(input logic [15:0] old_v,
	                                         input logic [15:0] new_v,
	                                         input logic [1:0]  be);
		merge_be = {be[1] ? new_v[15:8] : old_v[15:8],
		            be[0] ? new_v[7:0]  : old_v[7:0]};
	endfunction : merge_be

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [15:0] std_low_reg;
	logic [15:0] fast_high_reg;
	logic [15:0] fast_low_reg;
	logic [15:0] rdata_next;
	logic        cfg_wr_ok;
	logic        gc_clr_rd;
	logic        gc_evt;
	logic        rx_evt;
	logic [1:0]  evt_s;
	logic [1:0]  evt_prev_reg;
	ist_pkg::ist_bus_pins_t pins_s;
	logic [15:0] idle_cnt_reg;
	logic [15:0] idle_target;
	logic [15:0] std_high_eff;
	logic [15:0] sel_high;
	logic [15:0] sel_low;
	logic        scl_run;
	logic [15:0] scl_cnt_reg;
	logic [15:0] low_len_reg;

	ist_pkg::ist_bus_pins_t pins_l;
	ist_pkg::ist_bus_pins_t pins_l_prev_reg;
	logic        en_l;
	logic        rst_l_n;
	ist_pkg::ist_link_state_t state_reg;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  shift_reg;
	logic        gc_tog_reg;
	logic        rx_tog_reg;
	logic [7:0]  rx_byte_reg;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic        byte_done;
	logic        ack_addr;
	logic        ack_data;

	// ------------------------------------------------------------------
	// Crossings
	// ------------------------------------------------------------------
	ist_sync #(.W(2), .RST(2'b11)) u_pins_sys (
		.i_clk  (i_sys_clk),
		.i_nrst (i_nrst),
		.i_d    ({i_scl_in, i_sda_in}),
		.o_q    (pins_s)
	);

	ist_sync #(.W(2), .RST(2'b00)) u_evt_sys (
		.i_clk  (i_sys_clk),
		.i_nrst (i_nrst),
		.i_d    ({gc_tog_reg, rx_tog_reg}),
		.o_q    (evt_s)
	);

	ist_sync #(.W(2), .RST(2'b11)) u_pins_link (
		.i_clk  (i_link_clk),
		.i_nrst (i_nrst),
		.i_d    ({i_scl_in, i_sda_in}),
		.o_q    (pins_l)
	);

	ist_sync #(.W(1), .RST(1'b0)) u_en_link (
		.i_clk  (i_link_clk),
		.i_nrst (i_nrst),
		.i_d    (i_ctrl_enable),
		.o_q    (en_l)
	);

	// Reset release into the link domain is itself synchronised
	ist_sync #(.W(1), .RST(1'b0)) u_rst_link (
		.i_clk  (i_link_clk),
		.i_nrst (i_nrst),
		.i_d    (1'b1),
		.o_q    (rst_l_n)
	);

	// ------------------------------------------------------------------
	// Period count registers
	// ------------------------------------------------------------------
	assign cfg_wr_ok = i_req.wr && !i_ctrl_enable;

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			std_low_reg <= ist_pkg::STD_LOW_RST;
		end else if (cfg_wr_ok && i_req.addr == ist_pkg::STD_LOW_ADDR) begin
			std_low_reg <= clamp_min(merge_be(std_low_reg, i_req.wdata,
			                         i_req.be), ist_pkg::LOW_MIN);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			fast_high_reg <= ist_pkg::FAST_HIGH_RST;
		end else if (cfg_wr_ok && i_req.addr == ist_pkg::FAST_HIGH_ADDR) begin
			fast_high_reg <= clamp_min(merge_be(fast_high_reg, i_req.wdata,
			                           i_req.be), ist_pkg::HIGH_MIN);
		end
	end

	// Byte lanes merge, but each write is clamped to 8, so a low byte below 8 written over a zero high byte is stored as 8
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			fast_low_reg <= ist_pkg::FAST_LOW_RST;
		end else if (cfg_wr_ok && i_req.addr == ist_pkg::FAST_LOW_ADDR) begin
			fast_low_reg <= clamp_min(merge_be(fast_low_reg, i_req.wdata,
			                          i_req.be), ist_pkg::LOW_MIN);
		end
	end

	// ------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------
	always_comb begin
		rdata_next = '0;
		case (i_req.addr)
			ist_pkg::STD_LOW_ADDR:   rdata_next = std_low_reg;
			ist_pkg::FAST_HIGH_ADDR: rdata_next = fast_high_reg;
			ist_pkg::FAST_LOW_ADDR:  rdata_next = fast_low_reg;
			ist_pkg::INTR_STAT_ADDR: rdata_next[ist_pkg::GC_BIT] = o_gc_flag;
			ist_pkg::GC_CLR_ADDR:    rdata_next[ist_pkg::GC_CLR_BIT] = o_gc_flag;
			default:                 rdata_next = '0;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_reg_rdata <= '0;
		end else if (i_req.rd) begin
			o_reg_rdata <= rdata_next;
		end
	end

	// ------------------------------------------------------------------
	// General Call flag and receive hand-off
	// ------------------------------------------------------------------
	assign gc_evt    = evt_s[1] != evt_prev_reg[1];
	assign rx_evt    = evt_s[0] != evt_prev_reg[0];
	assign gc_clr_rd = i_req.rd && i_req.addr == ist_pkg::GC_CLR_ADDR;

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			evt_prev_reg <= '0;
		end else begin
			evt_prev_reg <= evt_s;
		end
	end

	// A new event beats a clear in the same cycle
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_gc_flag <= 1'b0;
		end else if (gc_evt) begin
			o_gc_flag <= 1'b1;
		end else if (!i_ctrl_enable || gc_clr_rd) begin
			o_gc_flag <= 1'b0;
		end
	end

	// Byte stays stable in the link domain until the next toggle
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_rx_data  <= '0;
			o_rx_valid <= 1'b0;
		end else begin
			o_rx_valid <= rx_evt;
			if (rx_evt) begin
				o_rx_data <= rx_byte_reg;
			end
		end
	end

	// ------------------------------------------------------------------
	// Bus idle detection
	// ------------------------------------------------------------------
	assign std_high_eff = clamp_min(i_std_high_count, ist_pkg::HIGH_MIN);
	assign idle_target  = std_high_eff + ist_pkg::IDLE_MARGIN;

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			idle_cnt_reg <= '0;
		end else if (!(pins_s.scl && pins_s.sda)) begin
			idle_cnt_reg <= '0;
		end else if (idle_cnt_reg != ist_pkg::CNT_MAX) begin
			idle_cnt_reg <= idle_cnt_reg + ist_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_bus_idle <= 1'b0;
		end else begin
			o_bus_idle <= idle_cnt_reg >= idle_target;
		end
	end

	// ------------------------------------------------------------------
	// Master SCL generation
	// ------------------------------------------------------------------
	// High-speed data phase reuses fast counts; no separate HS counts here
	always_comb begin
		sel_high = std_high_eff;
		sel_low  = std_low_reg;
		if (i_speed_mode == ist_pkg::SPD_FAST ||
		    i_speed_mode == ist_pkg::SPD_HIGH || i_hs_preamble) begin
			sel_high = fast_high_reg;
			sel_low  = fast_low_reg;
		end
	end

	assign scl_run = i_ctrl_enable && i_master_active;

	// No clock stretching: the phase length is purely the count
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst || !scl_run) begin
			scl_cnt_reg <= '0;
			o_scl_oe    <= 1'b0;
		end else if (o_scl_oe) begin
			// Reach or pass: a mode change mid-phase never wraps the count
			if (scl_cnt_reg >= sel_low - ist_pkg::CNT_ONE) begin
				scl_cnt_reg <= '0;
				o_scl_oe    <= 1'b0;
			end else begin
				scl_cnt_reg <= scl_cnt_reg + ist_pkg::CNT_ONE;
			end
		end else begin
			if (scl_cnt_reg >= sel_high - ist_pkg::CNT_ONE) begin
				scl_cnt_reg <= '0;
				o_scl_oe    <= 1'b1;
			end else begin
				scl_cnt_reg <= scl_cnt_reg + ist_pkg::CNT_ONE;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_scl_out   <= 1'b0;
			low_len_reg <= '0;
		end else begin
			o_scl_out   <= 1'b0;
			low_len_reg <= o_scl_oe ? low_len_reg + ist_pkg::CNT_ONE : '0;
		end
	end

	// ------------------------------------------------------------------
	// Link side: General Call receiver
	// ------------------------------------------------------------------
	always_ff @(posedge i_link_clk) begin
		if (!rst_l_n) begin
			pins_l_prev_reg <= 2'b11;
		end else begin
			pins_l_prev_reg <= pins_l;
		end
	end

	assign scl_rise  = pins_l.scl && !pins_l_prev_reg.scl;
	assign scl_fall  = !pins_l.scl && pins_l_prev_reg.scl;
	assign start_det = pins_l.scl && pins_l_prev_reg.scl &&
	                   pins_l_prev_reg.sda && !pins_l.sda;
	assign stop_det  = pins_l.scl && pins_l_prev_reg.scl &&
	                   !pins_l_prev_reg.sda && pins_l.sda;
	assign byte_done = scl_fall && bit_cnt_reg == ist_pkg::BITS_PER_BYTE;
	assign ack_addr  = en_l && byte_done && state_reg == ist_pkg::LK_ADDR &&
	                   shift_reg == ist_pkg::GC_ADDR_BYTE;
	assign ack_data  = en_l && byte_done && state_reg == ist_pkg::LK_DATA;

	always_ff @(posedge i_link_clk) begin
		if (!rst_l_n || !en_l) begin
			state_reg   <= ist_pkg::LK_IDLE;
			bit_cnt_reg <= '0;
			shift_reg   <= '0;
			o_sda_oe    <= 1'b0;
		end else if (start_det) begin
			state_reg   <= ist_pkg::LK_ADDR;
			bit_cnt_reg <= '0;
			o_sda_oe    <= 1'b0;
		end else if (stop_det) begin
			state_reg <= ist_pkg::LK_IDLE;
			o_sda_oe  <= 1'b0;
		end else begin
			case (state_reg)
				ist_pkg::LK_ADDR, ist_pkg::LK_DATA: begin
					if (scl_rise && bit_cnt_reg < ist_pkg::BITS_PER_BYTE) begin
						shift_reg   <= {shift_reg[6:0], pins_l.sda};
						bit_cnt_reg <= bit_cnt_reg + ist_pkg::BIT_ONE;
					end else if (byte_done) begin
						bit_cnt_reg <= '0;
						if (ack_addr || ack_data) begin
							state_reg <= ist_pkg::LK_ACK;
							o_sda_oe  <= 1'b1;
						end else begin
							state_reg <= ist_pkg::LK_IDLE;
						end
					end
				end
				ist_pkg::LK_ACK: begin
					if (scl_fall) begin
						state_reg <= ist_pkg::LK_DATA;
						o_sda_oe  <= 1'b0;
					end
				end
				default: begin
					state_reg <= ist_pkg::LK_IDLE;
				end
			endcase
		end
	end

	// Toggles survive disable so no false event appears
	always_ff @(posedge i_link_clk) begin
		if (!rst_l_n) begin
			gc_tog_reg  <= 1'b0;
			rx_tog_reg  <= 1'b0;
			rx_byte_reg <= '0;
			o_sda_out   <= 1'b0;
		end else begin
			o_sda_out <= 1'b0;
			if (ack_addr) begin
				gc_tog_reg <= !gc_tog_reg;
			end
			if (ack_data) begin
				rx_tog_reg  <= !rx_tog_reg;
				rx_byte_reg <= shift_reg;
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence s_addr_ack;
		ack_addr ##1 (o_sda_oe && state_reg == ist_pkg::LK_ACK);
	endsequence

	a_enabled_write_blocked: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		(i_ctrl_enable && i_req.wr) |=> ($stable(std_low_reg) &&
		$stable(fast_high_reg) && $stable(fast_low_reg)))
		else $error("period count changed while enabled");

	a_std_low_min: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		(cfg_wr_ok && i_req.addr == ist_pkg::STD_LOW_ADDR && i_req.be == 2'b11)
		|=> std_low_reg == (($past(i_req.wdata) < ist_pkg::LOW_MIN) ?
		ist_pkg::LOW_MIN : $past(i_req.wdata)))
		else $error("standard low count not clamped to minimum");

	a_fast_high_min: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		fast_high_reg >= ist_pkg::HIGH_MIN)
		else $error("fast high count below minimum");

	a_fast_low_min: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		fast_low_reg >= ist_pkg::LOW_MIN)
		else $error("fast low count below minimum");

	a_gc_flag_set: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		gc_evt |=> o_gc_flag)
		else $error("general call flag not set after event");

	a_gc_flag_hold: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		(o_gc_flag && i_ctrl_enable && !gc_clr_rd) |=> o_gc_flag)
		else $error("general call flag dropped without clear");

	a_gc_flag_clear: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		((!i_ctrl_enable || gc_clr_rd) && !gc_evt) |=> !o_gc_flag)
		else $error("general call flag not cleared");

	a_bus_idle_flag: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		(pins_s.scl && pins_s.sda && idle_cnt_reg < idle_target)
		|=> !o_bus_idle)
		else $error("bus idle flagged before count reached");

	a_scl_low_len: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		($fell(o_scl_oe) && scl_run && $past(scl_run) && $stable(sel_low))
		|-> low_len_reg == $past(sel_low))
		else $error("scl low phase length wrong");

	a_gc_ack_drive: assert property (@(posedge i_link_clk)
		disable iff (!rst_l_n)
		ack_addr && !start_det && !stop_det |-> s_addr_ack)
		else $error("general call not acknowledged");

	a_rx_handoff: assert property (@(posedge i_sys_clk)
		disable iff (!i_nrst)
		rx_evt |=> (o_rx_valid && o_rx_data == $past(rx_byte_reg)))
		else $error("received byte not passed on");

endmodule : ist_core

// >>> tb/ist_remote_master.sv
// Remote bus master model driving open-drain SCL and SDA
`timescale 1ns/1ps
module ist_remote_master (
	input  wire logic i_sda_line,
	output logic      o_scl_pull,
	output logic      o_sda_pull
);
	// Slow quarter-bit so the link-side sync delay never overlaps a rise
	localparam time QTR = 1000;

	initial begin
		o_scl_pull = 1'b0;
		o_sda_pull = 1'b0;
	end

	task automatic put_bit(input logic b, output logic seen);
		o_sda_pull = ~b;
		#QTR o_scl_pull = 1'b0;
		#QTR seen = i_sda_line;
		#QTR o_scl_pull = 1'b1;
		#QTR;
	endtask : put_bit

	task automatic start_cond();
		o_scl_pull = 1'b0;
		o_sda_pull = 1'b0;
		#QTR o_sda_pull = 1'b1;
		#QTR o_scl_pull = 1'b1;
		#QTR;
	endtask : start_cond

	// Ninth slot releases SDA so the device can acknowledge
	task automatic send_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(v[i], s);
		end
		put_bit(1'b1, s);
		ack = ~s;
	endtask : send_byte

	task automatic stop_cond();
		o_sda_pull = 1'b1;
		#QTR o_scl_pull = 1'b0;
		#QTR o_sda_pull = 1'b0;
		#QTR;
	endtask : stop_cond
endmodule : ist_remote_master

// >>> tb/ist_core_bench.sv
// Self-checking bench for the SCL timing and General Call block
`timescale 1ns/1ps
`define CHK(a, e) begin \
	tests_run++; \
	if ((a) !== (e)) begin \
		n_errors++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
	end \
end
module ist_core_bench;
	localparam logic [31:0] ADR [3] = '{ist_pkg::STD_LOW_ADDR,
		ist_pkg::FAST_HIGH_ADDR, ist_pkg::FAST_LOW_ADDR};
	localparam logic [15:0] MINS [3] = '{ist_pkg::LOW_MIN,
		ist_pkg::HIGH_MIN, ist_pkg::LOW_MIN};
	localparam logic [15:0] CRN [6] = '{16'h0000, 16'h0007, 16'h0008,
		16'h0005, 16'h0006, 16'hffff};
	localparam logic [1:0]  MODES [5] = '{2'b01, 2'b00, 2'b10, 2'b11, 2'b01};

	logic                  clk, link_clk, nrst, en, mact, hs;
	logic [1:0]            spd;
	logic [15:0]           hcnt, rdat;
	ist_pkg::ist_reg_req_t req;
	logic                  scl_oe, sda_oe, idle, gc, rxv, m_scl, m_sda;
	logic                  scl_o, sda_o;
	logic [7:0]            rxd, last_rx;
	logic [15:0]           sh [3];
	int                    n_errors, tests_run;
	wire                   scl_line = ~(scl_oe | m_scl);
	wire                   sda_line = ~(sda_oe | m_sda);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#23;
		forever #80 link_clk = ~link_clk;
	end

	ist_core uut (.i_sys_clk(clk), .i_nrst(nrst), .i_link_clk(link_clk),
		.i_req(req), .o_reg_rdata(rdat), .i_ctrl_enable(en),
		.i_master_active(mact), .i_speed_mode(spd), .i_hs_preamble(hs),
		.i_std_high_count(hcnt), .i_scl_in(scl_line), .i_sda_in(sda_line),
		.o_scl_out(scl_o), .o_scl_oe(scl_oe), .o_sda_out(sda_o),
		.o_sda_oe(sda_oe),
		.o_bus_idle(idle), .o_gc_flag(gc), .o_rx_data(rxd),
		.o_rx_valid(rxv));
	ist_remote_master peer (.i_sda_line(sda_line), .o_scl_pull(m_scl),
		.o_sda_pull(m_sda));

	always @(posedge clk) begin
		if (rxv === 1'b1) begin
			last_rx <= rxd;
		end
	end

	function automatic logic [15:0] merge(input logic [15:0] c, w,
		input logic [1:0] be, input logic [15:0] m);
		logic [15:0] v;
		v = {be[1] ? w[15:8] : c[15:8], be[0] ? w[7:0] : c[7:0]};
		return (v < m) ? m : v;
	endfunction : merge

	task automatic print_verdict();
		$display("errors=%0d checks=%0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task automatic rd(input logic [31:0] a, output logic [15:0] d);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 16'h0000, 2'b00};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 d = rdat;
	endtask : rd

	// Shadow follows only writes made while disabled
	task automatic wrk(input int k, input logic [15:0] d, input logic [1:0] be);
		@(posedge clk);
		req <= '{1'b1, 1'b0, ADR[k], d, be};
		@(posedge clk);
		req.wr <= 1'b0;
		if (!en) sh[k] = merge(sh[k], d, be, MINS[k]);
	endtask : wrk

	task automatic chk_reg(input int k);
		logic [15:0] v;
		rd(ADR[k], v);
		`CHK(v, sh[k])
	endtask : chk_reg

	// Counts cycles of one whole SCL phase at the given pull level
	task automatic phase(input logic lvl, output int n);
		int t;
		n = 0;
		t = 0;
		while (scl_oe !== !lvl && t < 9000) begin
			@(posedge clk);
			#1 t++;
		end
		while (scl_oe !== lvl && t < 9000) begin
			@(posedge clk);
			#1 t++;
		end
		while (scl_oe === lvl && t < 9000) begin
			@(posedge clk);
			#1 t++;
			n++;
		end
		if (t >= 9000) begin
			n_errors++;
			print_verdict();
		end
	endtask : phase

	task automatic gc_frame(input logic [7:0] adr, output logic ack);
		logic [7:0] b;
		logic       a2;
		b = 8'($urandom);
		peer.start_cond();
		peer.send_byte(adr, ack);
		if (ack) begin
			peer.send_byte(b, a2);
			`CHK(a2, 1'b1)
		end
		peer.stop_cond();
		repeat (20) @(posedge clk);
		#1;
		if (ack) `CHK(last_rx, b)
	endtask : gc_frame

	initial begin
		int          n;
		logic        a;
		logic [15:0] d;
		void'($urandom(32'hf5e4));
		{nrst, en, mact, hs, spd, hcnt} = '0;
		req = '0;
		n_errors = 0;
		tests_run = 0;
		sh = '{ist_pkg::STD_LOW_RST, ist_pkg::FAST_HIGH_RST,
			ist_pkg::FAST_LOW_RST};
		// Long enough for the link-side reset to settle as well
		repeat (100) @(posedge clk);
		nrst <= 1'b1;
		repeat (15) @(posedge clk);
		#1 `CHK(idle, 1'b0)
		repeat (15) @(posedge clk);
		#1 `CHK(idle, 1'b1)
		for (int k = 0; k < 3; k++) begin
			chk_reg(k);
			foreach (CRN[c]) begin
				wrk(k, CRN[c], 2'b11);
				chk_reg(k);
			end
		end
		wrk(2, 16'h0005, 2'b01);
		wrk(2, 16'h1200, 2'b10);
		chk_reg(2);
		repeat (20) begin
			n = $urandom_range(2);
			wrk(n, 16'($urandom), 2'($urandom));
			chk_reg(n);
		end
		rd(32'h5000_1324, d);
		`CHK(d, 16'h0000)
		rd(ist_pkg::INTR_STAT_ADDR, d);
		`CHK(d, 16'h0000)
		@(posedge clk);
		en <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			wrk(k, ~sh[k], 2'b11);
			chk_reg(k);
		end
		repeat (100) @(posedge clk);
		gc_frame(8'h00, a);
		`CHK(a, 1'b1)
		`CHK(gc, 1'b1)
		repeat (200) @(posedge clk);
		#1 `CHK(gc, 1'b1)
		rd(ist_pkg::INTR_STAT_ADDR, d);
		`CHK(d, 16'h0800)
		rd(ist_pkg::GC_CLR_ADDR, d);
		`CHK(d, 16'h0001)
		@(posedge clk);
		#1 `CHK(gc, 1'b0)
		gc_frame(8'h84, a);
		`CHK(a, 1'b0)
		`CHK(gc, 1'b0)
		gc_frame(8'h00, a);
		`CHK(gc, 1'b1)
		@(posedge clk);
		en <= 1'b0;
		repeat (3) @(posedge clk);
		#1 `CHK(gc, 1'b0)
		wrk(0, 16'h0020, 2'b11);
		wrk(1, 16'h0009, 2'b11);
		wrk(2, 16'h000c, 2'b11);
		@(posedge clk);
		{en, mact} <= 2'b11;
		hcnt <= 16'h0003;
		for (int m = 0; m < 5; m++) begin
			@(posedge clk);
			mact <= 1'b0;
			spd <= MODES[m];
			hs <= (m == 4);
			// Generator restarts so every mode begins with a whole phase
			@(posedge clk);
			mact <= 1'b1;
			phase(1'b1, n);
			phase(1'b1, n);
			`CHK(16'(n), (m >= 2) ? sh[2] : sh[0])
			phase(1'b0, n);
			`CHK(16'(n), (m >= 2) ? sh[1] : ist_pkg::HIGH_MIN)
		end
		`CHK({scl_o, sda_o}, 2'b00)
		print_verdict();
	end
endmodule : ist_core_bench
